// ---- include/sdsc_consts.vh ----
`ifndef SDSC_CONSTS_VH
`define SDSC_CONSTS_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define SDSC_ADDR_CTRL      12'h000
`define SDSC_ADDR_SW_CUR    12'h004
`define SDSC_ADDR_SW_STEP   12'h008
`define SDSC_ADDR_FAULT     12'h00C
`define SDSC_ADDR_STATUS    12'h010
`define SDSC_ADDR_CURRENT   12'h014
`define SDSC_ADDR_STEPS     12'h018

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SDSC_CTRL_SWMODE_BIT 0
`define SDSC_CTRL_RESET      32'h00000000
`define SDSC_SW_CUR_RESET    16'h0032
`define SDSC_SW_STEP_RESET   10'h0C8
`define SDSC_FAULT_W         3

// ----------------------------------------------------------------
// timing (ns figures and derived cycle counts)
// ----------------------------------------------------------------
`define SDSC_CLK_NS          8
`define SDSC_STILL_NS        400000000
`define SDSC_STILL_CYC       (`SDSC_STILL_NS / `SDSC_CLK_NS)
`define SDSC_TOGGLE_NS       1000000000
`define SDSC_TOGGLE_CYC      (`SDSC_TOGGLE_NS / `SDSC_CLK_NS)
`define SDSC_DEBOUNCE_NS     5000000
`define SDSC_DEBOUNCE_CYC    (`SDSC_DEBOUNCE_NS / `SDSC_CLK_NS)
`define SDSC_BLINK_NS        250000000
`define SDSC_BLINK_CYC       (`SDSC_BLINK_NS / `SDSC_CLK_NS)
`define SDSC_REDUCE_PCT      60

`endif

// ---- verilog/sdsc_drive_config.v ----
// Overview of operation
// - switch bank sets current and microsteps unless software mode
// - current from three current-select switches
// - microsteps from four step-select switches
// - current switches all off uses software current
// - current codes 1-7 map to peak amps
// - step switches all on uses software microsteps
// - step codes 1-7 map 400 to 25600
// - step codes 8-15 map 1000 to 25000
// - standstill switch on enables current reduction
// - reduced current is 60 percent of selected
// - reduction starts 0.4 s after last pulse
// - two standstill toggles in 1 s start autotune
// - differential pulse, direction, enable inputs accepted
// - green when powered, red when faulted
// - fault de-energises motor windings
// - fault latched until power cycle
// - red blinks fault-specific count per period
`timescale 1ns/1ps
`include "sdsc_consts.vh"

module sdsc_drive_config #(
  parameter integer STILL_CYC    = `SDSC_STILL_CYC,
  parameter integer TOGGLE_CYC   = `SDSC_TOGGLE_CYC,
  parameter integer DEBOUNCE_CYC = `SDSC_DEBOUNCE_CYC,
  parameter integer BLINK_CYC    = `SDSC_BLINK_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [7:0]  switch_in,
  input  wire        pulse_in_pos,
  input  wire        pulse_in_neg,
  input  wire        dir_in_pos,
  input  wire        dir_in_neg,
  input  wire        enable_in_pos,
  input  wire        enable_in_neg,
  input  wire [2:0]  fault_src,
  output reg  [15:0] current_cmd_q,
  output reg  [9:0]  microstep_q,
  output reg  [15:0] steps_rev_q,
  output reg         step_q,
  output reg         dir_q,
  output reg         windings_on_q,
  output reg         autotune_start_q,
  output wire        led_green,
  output reg         led_red_q
);

  // ----------------------------------------------------------------
  // input synchronisers and debounce
  // ----------------------------------------------------------------
  reg  [13:0] sync1_q;
  reg  [13:0] sync2_q;
  wire [7:0]  sw_q;
  // both legs synchronised apart; gating raw pins could glitch
  wire [13:0] raw_in = {enable_in_neg, dir_in_neg, pulse_in_neg,
                        enable_in_pos, dir_in_pos, pulse_in_pos, switch_in};
  // logic 1 is positive leg high and negative leg low
  wire [2:0]  diff_s = sync2_q[10:8] & ~sync2_q[13:11];

  // two stages before any logic looks at a switch or differential pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // one counter per switch; bounce shorter than the window never lands
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_deb
      reg [31:0] cnt_q;
      reg        bit_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= 32'h00000000;
          bit_q <= 1'b0;
        end else if (sync2_q[gi] == bit_q) begin
          cnt_q <= 32'h00000000;
        end else if (cnt_q >= DEBOUNCE_CYC - 1) begin
          cnt_q <= 32'h00000000;
          bit_q <= sync2_q[gi];
        end else begin
          cnt_q <= cnt_q + 32'h00000001;
        end
      end
      assign sw_q[gi] = bit_q;
    end
  endgenerate

  // switch is on when its bit is high
  wire [2:0] cur_code  = sw_q[2:0];
  wire       still_en  = sw_q[3];
  wire [3:0] step_code = ~sw_q[7:4]; // off reads as 1

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  reg         ctrl_q;
  reg  [15:0] sw_cur_q;
  reg  [9:0]  sw_step_q;
  reg  [`SDSC_FAULT_W-1:0] fault_q;
  wire        wr_en = psel & penable & pwrite;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // software writes; zero-wait slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= 1'b0;
      sw_cur_q  <= `SDSC_SW_CUR_RESET;
      sw_step_q <= `SDSC_SW_STEP_RESET;
    end else if (wr_en) begin
      case (paddr)
        `SDSC_ADDR_CTRL:    ctrl_q    <= pwdata[`SDSC_CTRL_SWMODE_BIT];
        `SDSC_ADDR_SW_CUR:  sw_cur_q  <= pwdata[15:0];
        `SDSC_ADDR_SW_STEP: sw_step_q <= pwdata[9:0];
        default:            ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // read mux; unmapped reads as zero
  always @* begin
    case (paddr)
      `SDSC_ADDR_CTRL:    prdata = {31'h00000000, ctrl_q};
      `SDSC_ADDR_SW_CUR:  prdata = {16'h0000, sw_cur_q};
      `SDSC_ADDR_SW_STEP: prdata = {22'h000000, sw_step_q};
      `SDSC_ADDR_FAULT:   prdata = {29'h00000000, fault_q};
      `SDSC_ADDR_STATUS:  prdata = {20'h00000, windings_on_q, dir_q, still_en, sw_q,
                                    1'b0};
      `SDSC_ADDR_CURRENT: prdata = {16'h0000, current_cmd_q};
      `SDSC_ADDR_STEPS:   prdata = {6'h00, microstep_q, steps_rev_q};
      default:            prdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // current and microstep decode
  // ----------------------------------------------------------------
  reg [15:0] cur_sel;  // units of 10 mA peak
  reg [15:0] steps_sel;

  // current table, code 0 falls back to software value
  always @* begin
    case (cur_code)
      3'h1:    cur_sel = 16'h00D2;
      3'h2:    cur_sel = 16'h010E;
      3'h3:    cur_sel = 16'h0140;
      3'h4:    cur_sel = 16'h017C;
      3'h5:    cur_sel = 16'h01AE;
      3'h6:    cur_sel = 16'h01EA;
      3'h7:    cur_sel = 16'h0230;
      default: cur_sel = sw_cur_q;
    endcase
    if (ctrl_q)
      cur_sel = sw_cur_q;
  end

  // step table, code 0 (all on) falls back to software value
  always @* begin
    case (step_code)
      4'h1:    steps_sel = 16'h0190;
      4'h2:    steps_sel = 16'h0320;
      4'h3:    steps_sel = 16'h0640;
      4'h4:    steps_sel = 16'h0C80;
      4'h5:    steps_sel = 16'h1900;
      4'h6:    steps_sel = 16'h3200;
      4'h7:    steps_sel = 16'h6400;
      4'h8:    steps_sel = 16'h03E8;
      4'h9:    steps_sel = 16'h07D0;
      4'hA:    steps_sel = 16'h0FA0;
      4'hB:    steps_sel = 16'h1388;
      4'hC:    steps_sel = 16'h1F40;
      4'hD:    steps_sel = 16'h2710;
      4'hE:    steps_sel = 16'h4E20;
      4'hF:    steps_sel = 16'h61A8;
      default: steps_sel = 16'h0000;
    endcase
    if (ctrl_q)
      steps_sel = 16'h0000;
  end

  // ----------------------------------------------------------------
  // step pulses and standstill timer
  // ----------------------------------------------------------------
  reg        pulse_d1_q;
  reg [31:0] idle_q;
  reg        reduced_q;
  wire       pulse_rise = diff_s[0] & ~pulse_d1_q;
  wire [31:0] cur_red = (cur_sel * `SDSC_REDUCE_PCT) / 100;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_d1_q <= 1'b0;
      idle_q     <= 32'h00000000;
      reduced_q  <= 1'b0;
      step_q     <= 1'b0;
      dir_q      <= 1'b0;
    end else begin
      pulse_d1_q <= diff_s[0];
      step_q     <= pulse_rise & windings_on_q;
      dir_q      <= diff_s[1];
      if (pulse_rise) begin
        idle_q    <= 32'h00000000;
        reduced_q <= 1'b0;
      end else if (idle_q < STILL_CYC - 1) begin
        idle_q <= idle_q + 32'h00000001;
      end else begin
        reduced_q <= 1'b1;
      end
    end
  end

  // commanded outputs; microsteps can change mid-move, controller's duty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_cmd_q <= 16'h0000;
      microstep_q   <= `SDSC_SW_STEP_RESET;
      steps_rev_q   <= 16'h0000;
    end else begin
      steps_rev_q <= steps_sel;
      microstep_q <= (steps_sel == 16'h0000) ? sw_step_q : steps_sel[15:6];
      if (!windings_on_q)
        current_cmd_q <= 16'h0000;
      else if (still_en && reduced_q)
        current_cmd_q <= cur_red[15:0];
      else
        current_cmd_q <= cur_sel;
    end
  end

  // ----------------------------------------------------------------
  // double toggle of standstill switch starts self-test
  // ----------------------------------------------------------------
  reg        still_d1_q;
  reg        armed_q;
  reg [31:0] win_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      still_d1_q       <= 1'b0;
      armed_q          <= 1'b0;
      win_q            <= 32'h00000000;
      autotune_start_q <= 1'b0;
    end else begin
      still_d1_q       <= still_en;
      autotune_start_q <= 1'b0;
      if (still_en != still_d1_q) begin
        if (armed_q) begin
          armed_q          <= 1'b0;
          autotune_start_q <= 1'b1;
        end else begin
          armed_q <= 1'b1;
          win_q   <= 32'h00000000;
        end
      end else if (armed_q) begin
        if (win_q >= TOGGLE_CYC - 1)
          armed_q <= 1'b0; // second change came too late
        else
          win_q <= win_q + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault latch and indicators
  // ----------------------------------------------------------------
  reg [31:0] blink_q;
  reg [3:0]  phase_q;

  assign led_green = presetn;

  // only power-on reset clears the fault; lowest source index wins code
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q       <= 3'h0;
      windings_on_q <= 1'b0;
    end else begin
      if (fault_q == 3'h0 && fault_src != 3'h0)
        fault_q <= fault_src[0] ? 3'h1 : (fault_src[1] ? 3'h2 : 3'h3);
      windings_on_q <= (fault_q == 3'h0) && (fault_src == 3'h0) && diff_s[2];
    end
  end

  // red blinks fault_q times then dark for the rest of 16 slots
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_q   <= 32'h00000000;
      phase_q   <= 4'h0;
      led_red_q <= 1'b0;
    end else if (fault_q == 3'h0) begin
      blink_q   <= 32'h00000000;
      phase_q   <= 4'h0;
      led_red_q <= 1'b0;
    end else begin
      if (blink_q >= BLINK_CYC - 1) begin
        blink_q <= 32'h00000000;
        phase_q <= phase_q + 4'h1; // wraps every 16 slots
      end else begin
        blink_q <= blink_q + 32'h00000001;
      end
      led_red_q <= ~phase_q[0] && (phase_q[3:1] < fault_q);
    end
  end

endmodule // sdsc_drive_config

// ---- tb/sdsc_drive_config_props.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// port checker
// ---------------------------------------------
module sdsc_drive_config_props #(
  parameter integer STILL_CYC = 50
) (
  input wire        pclk,
  input wire        presetn,
  input wire        pulse_in_pos,
  input wire        pulse_in_neg,
  input wire [2:0]  fault_src,
  input wire [15:0] current_cmd_q,
  input wire        step_q,
  input wire        windings_on_q,
  input wire        autotune_start_q,
  input wire        led_green,
  input wire        led_red_q
);
  localparam integer MIN_IDLE = STILL_CYC - 4; // slack for the input synchroniser
  wire        pulse_diff = pulse_in_pos & ~pulse_in_neg;
  reg         flt_q;
  reg  [31:0] idle_q;
  // fault memory and idle time since the last step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q  <= 1'b0;
      idle_q <= 32'h0;
    end else begin
      flt_q  <= flt_q | (|fault_src);
      idle_q <= step_q ? 32'h0 : idle_q + 32'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_green_on: assert property (led_green)
    else $error("green indicator off while powered");
  chk_fault_free: assert property (|fault_src |-> ##[1:3] !windings_on_q)
    else $error("windings still on after a trip");
  chk_fault_held: assert property (flt_q |-> ##2 !windings_on_q)
    else $error("windings back on after a latched fault");
  chk_red_cause: assert property (led_red_q |-> flt_q)
    else $error("red indicator without a fault");
  chk_step_single: assert property (step_q |=> !step_q)
    else $error("step output longer than one cycle");
  chk_step_cause: assert property (step_q |-> $past(pulse_diff, 3) || $past(pulse_diff, 5)
    || $past(pulse_diff, 4))
    else $error("step output without a pulse at the pins");
  chk_tune_single: assert property (autotune_start_q |=> !autotune_start_q)
    else $error("self-test start longer than one cycle");
  chk_reduce_wait: assert property (windings_on_q && current_cmd_q != 16'h0
    && current_cmd_q * 10 == $past(current_cmd_q) * 6 |-> idle_q >= MIN_IDLE)
    else $error("standstill reduction came too early");
endmodule // sdsc_drive_config_props
bind sdsc_drive_config sdsc_drive_config_props #(.STILL_CYC(STILL_CYC)) sdsc_drive_config_props_i (
  .pclk, .presetn, .pulse_in_pos, .pulse_in_neg, .fault_src, .current_cmd_q, .step_q,
  .windings_on_q, .autotune_start_q, .led_green, .led_red_q);

// ---- tb/sdsc_motion_ctl.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// motion controller model
// ---------------------------------------------
module sdsc_motion_ctl (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [7:0] count,
  input  wire       dir,
  input  wire       en,
  output reg        busy_q,
  output wire       pulse_in_pos,
  output wire       pulse_in_neg,
  output wire       dir_in_pos,
  output wire       dir_in_neg,
  output wire       enable_in_pos,
  output wire       enable_in_neg
);
  reg [7:0] left_q;
  reg [1:0] tick_q;
  reg       pulse_q;
  // pulses three cycles high, three low; a count of zero is never asked for
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q  <= 1'b0;
      left_q  <= 8'h00;
      tick_q  <= 2'h0;
      pulse_q <= 1'b0;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      left_q <= count;
      tick_q <= 2'h2;
    end else if (busy_q && tick_q != 2'h0) begin
      tick_q <= tick_q - 2'h1;
    end else if (busy_q) begin
      tick_q  <= 2'h2;
      pulse_q <= ~pulse_q;
      left_q  <= left_q - {7'h00, pulse_q};
      busy_q  <= !(pulse_q && left_q == 8'h01);
    end
  end
  // complementary legs of each pair
  assign pulse_in_pos  = pulse_q;
  assign pulse_in_neg  = ~pulse_q;
  assign dir_in_pos    = dir;
  assign dir_in_neg    = ~dir;
  assign enable_in_pos = en;
  assign enable_in_neg = ~en;
endmodule // sdsc_motion_ctl

// ---- tb/sdsc_drive_config_tb_top.sv ----
`timescale 1ns/1ps
`include "sdsc_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module sdsc_drive_config_tb_top;
  // ---------------------------------------------
  // stimulus, expectation queue and monitor
  // ---------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0, dir = 0, en = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q, g;
  logic [7:0] switch_in = 8'h00, cnt = 8'h01;
  logic [2:0] fault_src = 3'h0;
  logic [15:0] current_cmd_q, steps_rev_q;
  logic [9:0] microstep_q;
  logic pready, pslverr, step_q, dir_q, windings_on_q, autotune_start_q, led_green, led_red_q;
  logic pulse_in_pos, pulse_in_neg, dir_in_pos, dir_in_neg, enable_in_pos, enable_in_neg;
  logic busy_q, red_d = 0;
  logic [35:0] q[$], e;
  int fails = 0, compares = 0, seed = 8, sw_cur, sw_ms, step_n = 0, tune_n = 0, red_n = 0, b;
  int cur[8] = '{0, 210, 270, 320, 380, 430, 490, 560};
  int st[16] = '{0, 400, 800, 1600, 3200, 6400, 12800, 25600,
                 1000, 2000, 4000, 5000, 8000, 10000, 20000, 25000};
  sdsc_drive_config #(.STILL_CYC(50), .TOGGLE_CYC(200), .DEBOUNCE_CYC(4), .BLINK_CYC(8))
    sdsc_drive_config_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .switch_in, .pulse_in_pos, .pulse_in_neg, .dir_in_pos, .dir_in_neg,
    .enable_in_pos, .enable_in_neg, .fault_src, .current_cmd_q, .microstep_q, .steps_rev_q,
    .step_q, .dir_q, .windings_on_q, .autotune_start_q, .led_green, .led_red_q);
  sdsc_motion_ctl sdsc_motion_ctl_i (.pclk, .presetn, .start, .count(cnt), .dir, .en, .busy_q,
    .pulse_in_pos, .pulse_in_neg, .dir_in_pos, .dir_in_neg, .enable_in_pos, .enable_in_neg);
  always #4 pclk = ~pclk;
  // event counters for steps, self-test starts and red blinks
  always @(posedge pclk) begin
    step_n <= step_n + step_q;
    tune_n <= tune_n + autotune_start_q;
    red_d <= led_red_q;
    red_n <= red_n + (led_red_q && !red_d);
  end
  // settled half a cycle after the edge; oldest note first
  always @(negedge pclk) while (q.size() > 0) begin
    e = q.pop_front();
    case (e[35:32])
      0: g = {16'h0, current_cmd_q};
      1: g = {16'h0, steps_rev_q};
      2: g = rd_q;
      3: g = {31'h0, windings_on_q};
      4: g = {22'h0, microstep_q};
      5: g = step_n;
      6: g = tune_n;
      7: g = red_n;
      8: g = {31'h0, led_green};
      default: g = {30'h0, pslverr, dir_q};
    endcase
    `CHK(g, e[31:0])
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic note(input int k, input int x);
    q.push_back({k[3:0], x[31:0]});
    cyc(1);
  endtask
  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // setup, then access held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin fails++; conclude(); end
    rd_q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    cyc(1); // idle edge so a following call never re-drives psel at once
  endtask
  task automatic rd(input logic [11:0] a, input int x);
    apb(1'b0, a, 32'h0);
    note(2, x);
  endtask
  // switches only move while the motor is idle
  task automatic sw(input logic [7:0] v);
    switch_in <= v;
    cyc(16);
  endtask
  task automatic move(input int n);
    cnt <= n[7:0];
    start <= 1'b1;
    cyc(2);
    start <= 1'b0;
    for (int k = 0; k < 300 && busy_q; k++) cyc(1);
    if (busy_q) begin fails++; conclude(); end
    cyc(8);
  endtask
  initial begin
    sw_cur = (50 + {$random(seed)} % 510) | 1; // odd, so never 60% of a table step
    sw_ms = 1 + {$random(seed)} % 512;
    cyc(12);
    presetn <= 1'b1;
    en <= 1'b1;
    cyc(2);
    rd(`SDSC_ADDR_CTRL, 0);
    rd(`SDSC_ADDR_SW_CUR, 50);
    rd(`SDSC_ADDR_SW_STEP, 200);
    rd(12'h020, 0);
    note(8, 1);
    apb(1'b1, `SDSC_ADDR_SW_CUR, sw_cur);
    apb(1'b1, `SDSC_ADDR_SW_STEP, sw_ms);
    for (int c = 0; c < 8; c++) begin
      sw({5'h00, c[2:0]});
      note(0, c ? cur[c] : sw_cur);
    end
    apb(1'b1, `SDSC_ADDR_CTRL, 1);
    cyc(4);
    note(0, sw_cur);
    apb(1'b1, `SDSC_ADDR_CTRL, 0);
    for (int s = 0; s < 16; s++) begin
      sw({~s[3:0], 4'h7});
      note(1, st[s]);
      note(4, s ? st[s] / 64 : sw_ms);
    end
    $display("done: switch decode");
    sw(8'h0F);
    move(3);
    note(5, 3);
    note(0, 560);
    cyc(60);
    note(0, 336);
    move(1);
    note(0, 560);
    cyc(150);
    sw(8'h07);
    cyc(60);
    note(0, 560);
    $display("done: standstill");
    en <= 1'b0;
    cyc(6);
    note(3, 0);
    en <= 1'b1;
    dir <= 1'b1;
    cyc(6);
    note(3, 1);
    note(9, 1);
    cyc(150);
    repeat (2) begin
      switch_in <= 8'h0F;
      cyc(1);
      switch_in <= 8'h07;
      cyc(3);
    end
    cyc(20);
    note(6, 0);
    sw(8'h0F);
    sw(8'h07);
    note(6, 1);
    cyc(220);
    sw(8'h0F);
    cyc(220);
    sw(8'h07);
    note(6, 1);
    $display("done: self-test");
    fault_src <= 3'h2;
    cyc(1);
    fault_src <= 3'h0;
    cyc(10);
    note(3, 0);
    note(0, 0);
    rd(`SDSC_ADDR_FAULT, 2);
    b = red_n;
    cyc(126);
    note(7, b + 2);
    move(2);
    note(5, 4);
    note(3, 0);
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(12);
    note(3, 1);
    rd(`SDSC_ADDR_FAULT, 0);
    $display("done: fault");
    conclude();
  end
endmodule // sdsc_drive_config_tb_top
